//--- hdl/ccd_top.sv
// module: two channel clock dividers with their apb register file
//
// Behaviour
// - output stays low for low-cycle field plus one input cycles.
// - output stays high for high-cycle field plus one input cycles.
// - bypass powers down and passes input; div 0 resets bypassed.
// - sync-ignore clear obeys chip sync; set ignores it.
// - force bit drives output high, only when sync-ignore is also set.
// - start-level bit picks the level the output starts with.
// - a four-bit phase offset, reset to zero, shifts output timing.
// - direct route: oscillator on 10b, clock on 00b, divider otherwise.
// - duty correction is on when its disable bit is clear, reset clear.
`timescale 1ns/10ps
module ccd_top
	import ccd_pkg::*;
#(
	parameter int unsigned OSC_HALF = CCD_OSC_HALF_CYC // oscillator half period
)
(
	input wire logic pclk, // system clock, 40 MHz
	input wire logic presetn, // async reset, active low
	input wire logic psel, // apb select
	input wire logic penable, // apb access phase
	input wire logic pwrite, // apb direction, high for write
	input wire logic [ccd_pkg::CCD_AW-1:0] paddr, // apb byte address
	input wire logic [31:0] pwdata, // apb write data
	input wire logic [3:0] pstrb, // apb byte strobes
	output logic [31:0] prdata, // apb read data
	output logic pready, // apb ready
	output logic pslverr, // apb error
	input wire logic clk_in, // external clock input pin
	input wire logic sync_n, // chip-level sync pin, active low
	output logic first_pair_output_a, // divider 0 pair, output a
	output logic first_pair_output_b, // divider 0 pair, output b
	output logic second_pair_output_a, // divider 1 pair, output a
	output logic second_pair_output_b, // divider 1 pair, output b
	output logic [1:0] duty_correction_on // correction enable per pair
);
	logic [7:0] div0_phase_q, div0_phase_d;
	logic [7:0] div0_ctrl_q, div0_ctrl_d;
	logic [7:0] div0_route_q, div0_route_d;
	logic [7:0] div1_phase_q, div1_phase_d;
	logic [7:0] div1_ctrl_q, div1_ctrl_d;
	logic [7:0] src_sel_q, src_sel_d;
	logic [31:0] prdata_q, prdata_d;
	logic pready_q, pready_d;
	logic pslverr_q, pslverr_d;
	logic [CCD_IW-1:0] idx;
	logic [7:0] rd_byte;
	logic hit;
	logic read_only;
	logic sync_meta_q, sync_q;
	logic clk_meta_q, clk_q, clk_dly_q;
	logic [7:0] osc_cnt_q, osc_cnt_d;
	logic osc_q, osc_d;
	logic in_level;
	logic in_tick;
	logic [1:0] src;
	logic [7:0] phase_w [2];
	logic [7:0] ctrl_w [2];
	logic direct_w [2];
	logic dcc_dis_w [2];
	logic pair_q [2];
	logic pair_d [2];
	logic running_w [2];
	logic [1:0] dcc_q, dcc_d;

	assign idx = paddr[CCD_IW+1:2];
	assign src = src_sel_q[1:0];

	// read decode; misaligned or unknown addresses answer with an error
	always_comb
	begin
		rd_byte = 8'h00;
		hit = (paddr[1:0] == 2'h0);
		read_only = 1'b0;
		case (idx)
			CCD_IDX_DIV0_PHASE: rd_byte = div0_phase_q;
			CCD_IDX_DIV0_CTRL: rd_byte = div0_ctrl_q;
			CCD_IDX_DIV0_ROUTE: rd_byte = div0_route_q;
			CCD_IDX_DIV1_PHASE: rd_byte = div1_phase_q;
			CCD_IDX_DIV1_CTRL: rd_byte = div1_ctrl_q;
			CCD_IDX_SRC_SEL: rd_byte = src_sel_q;
			CCD_IDX_STATUS:
			begin
				rd_byte = {4'h0, running_w[1], running_w[0], pair_q[1],
					pair_q[0]};
				read_only = 1'b1;
			end
			default: hit = 1'b0;
		endcase
	end

	// apb slave: one wait state, answer prepared in the first access cycle
	always_comb
	begin
		prdata_d = prdata_q;
		pready_d = 1'b0;
		pslverr_d = pslverr_q;
		div0_phase_d = div0_phase_q;
		div0_ctrl_d = div0_ctrl_q;
		div0_route_d = div0_route_q;
		div1_phase_d = div1_phase_q;
		div1_ctrl_d = div1_ctrl_q;
		src_sel_d = src_sel_q;
		if (psel && penable && !pready_q)
		begin
			pready_d = 1'b1;
			prdata_d = pwrite ? 32'h0000_0000 : {24'h00_0000, rd_byte};
			pslverr_d = !hit || (pwrite && read_only);
		end
		// write lands on the edge that completes the transfer
		if (psel && penable && pready_q && pwrite && !pslverr_q && pstrb[0])
		begin
			case (idx)
				CCD_IDX_DIV0_PHASE: div0_phase_d = pwdata[7:0];
				CCD_IDX_DIV0_CTRL: div0_ctrl_d = pwdata[7:0];
				CCD_IDX_DIV0_ROUTE:
					div0_route_d = pwdata[7:0] & CCD_MASK_ROUTE;
				CCD_IDX_DIV1_PHASE: div1_phase_d = pwdata[7:0];
				CCD_IDX_DIV1_CTRL:
					div1_ctrl_d = pwdata[7:0] & CCD_MASK_DIV1_CTRL;
				CCD_IDX_SRC_SEL: src_sel_d = pwdata[7:0] & CCD_MASK_ROUTE;
				default: src_sel_d = src_sel_q;
			endcase
		end
	end

	// register file and bus answer flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			div0_phase_q <= CCD_RST_DIV0_PHASE;
			div0_ctrl_q <= CCD_RST_DIV0_CTRL;
			div0_route_q <= CCD_RST_DIV0_ROUTE;
			div1_phase_q <= CCD_RST_DIV1_PHASE;
			div1_ctrl_q <= CCD_RST_DIV1_CTRL;
			src_sel_q <= CCD_RST_SRC_SEL;
			prdata_q <= 32'h0000_0000;
			pready_q <= 1'b0;
			pslverr_q <= 1'b0;
		end
		else
		begin
			div0_phase_q <= div0_phase_d;
			div0_ctrl_q <= div0_ctrl_d;
			div0_route_q <= div0_route_d;
			div1_phase_q <= div1_phase_d;
			div1_ctrl_q <= div1_ctrl_d;
			src_sel_q <= src_sel_d;
			prdata_q <= prdata_d;
			pready_q <= pready_d;
			pslverr_q <= pslverr_d;
		end
	end

	assign prdata = prdata_q;
	assign pready = pready_q;
	assign pslverr = pslverr_q;

	// internal oscillator model: free-running toggle from pclk
	always_comb
	begin
		osc_cnt_d = osc_cnt_q + 8'h01;
		osc_d = osc_q;
		if (osc_cnt_q >= 8'(OSC_HALF - 1))
		begin
			osc_cnt_d = 8'h00;
			osc_d = !osc_q;
		end
	end

	// pin synchronisers; first stages feed only the second stages
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			sync_meta_q <= 1'b1;
			sync_q <= 1'b1;
			clk_meta_q <= 1'b0;
			clk_q <= 1'b0;
			clk_dly_q <= 1'b0;
			osc_cnt_q <= 8'h00;
			osc_q <= 1'b0;
		end
		else
		begin
			sync_meta_q <= sync_n;
			sync_q <= sync_meta_q;
			clk_meta_q <= clk_in;
			clk_q <= clk_meta_q;
			clk_dly_q <= clk_q;
			osc_cnt_q <= osc_cnt_d;
			osc_q <= osc_d;
		end
	end

	// divider input: oscillator on 10b, otherwise the clock pin
	assign in_level = (src == CCD_SRC_OSC) ? osc_q : clk_q;
	assign in_tick = (src == CCD_SRC_OSC) ? (osc_d && !osc_q) :
		(clk_q && !clk_dly_q);

	// channel 1 has no route register, start level or offset
	assign phase_w[0] = div0_phase_q;
	assign phase_w[1] = div1_phase_q;
	assign ctrl_w[0] = div0_ctrl_q;
	assign ctrl_w[1] = div1_ctrl_q;
	assign direct_w[0] = div0_route_q[CCD_BIT_DIRECT];
	assign direct_w[1] = 1'b0;
	assign dcc_dis_w[0] = div0_route_q[CCD_BIT_DCC_DIS];
	assign dcc_dis_w[1] = 1'b0;

	genvar ch;
	generate
		for (ch = 0; ch < 2; ch++)
		begin : gen_ch
			ccd_div_if dif ();
			assign dif.tick = in_tick;
			// chip sync stops a divider and clears its count unless it ignores sync
			assign dif.hold = ctrl_w[ch][CCD_BIT_BYPASS] ||
				(!sync_q && !ctrl_w[ch][CCD_BIT_NOSYNC]);
			assign dif.start_high = ctrl_w[ch][CCD_BIT_START];
			assign dif.low_len = phase_w[ch][CCD_LOW_MSB:CCD_LOW_LSB];
			assign dif.high_len = phase_w[ch][CCD_HIGH_MSB:CCD_HIGH_LSB];
			assign dif.phase_off = ctrl_w[ch][CCD_OFS_MSB:CCD_OFS_LSB];
			assign running_w[ch] = dif.running;

			ccd_divider u_div (
				.pclk (pclk),
				.presetn (presetn),
				.dif (dif)
			);

			// pair source priority: direct route, bypass, force, divider
			always_comb
			begin
				if (direct_w[ch] && src == CCD_SRC_OSC)
					pair_d[ch] = osc_q;
				else if (direct_w[ch] && src == CCD_SRC_CLK)
					pair_d[ch] = clk_q;
				else if (ctrl_w[ch][CCD_BIT_BYPASS])
					pair_d[ch] = in_level;
				else if (ctrl_w[ch][CCD_BIT_NOSYNC] &&
					ctrl_w[ch][CCD_BIT_FORCE])
					pair_d[ch] = 1'b1;
				else
					pair_d[ch] = dif.level;
				dcc_d[ch] = !dcc_dis_w[ch];
			end

			// pair and correction flops
			always_ff @(posedge pclk or negedge presetn)
			begin
				if (!presetn)
				begin
					pair_q[ch] <= 1'b0;
					dcc_q[ch] <= 1'b1;
				end
				else
				begin
					pair_q[ch] <= pair_d[ch];
					dcc_q[ch] <= dcc_d[ch];
				end
			end
		end
	endgenerate

	// both outputs of a pair carry the same level; polarity is downstream
	assign first_pair_output_a = pair_q[0];
	assign first_pair_output_b = pair_q[0];
	assign second_pair_output_a = pair_q[1];
	assign second_pair_output_b = pair_q[1];
	assign duty_correction_on = dcc_q;

	AST_BYPASS: assert property (@(posedge pclk)
		disable iff (!presetn)
		(div0_ctrl_q[CCD_BIT_BYPASS] && !direct_w[0]) |=>
		first_pair_output_a == $past(in_level))
		else $error("bypassed pair does not follow the input clock");
	AST_FORCE: assert property (@(posedge pclk)
		disable iff (!presetn)
		(ctrl_w[1][CCD_BIT_NOSYNC] && ctrl_w[1][CCD_BIT_FORCE] &&
		!ctrl_w[1][CCD_BIT_BYPASS]) |=> second_pair_output_a)
		else $error("forced pair is not high");
	AST_DIRECT: assert property (@(posedge pclk)
		disable iff (!presetn)
		(direct_w[0] && src == CCD_SRC_OSC) |=>
		first_pair_output_b == $past(osc_q))
		else $error("direct route does not carry the oscillator");
	// the clock pin route bypasses the divider just like the oscillator
	AST_DIRECT_CLK: assert property (@(posedge pclk)
		disable iff (!presetn)
		(direct_w[0] && src == CCD_SRC_CLK) |=>
		first_pair_output_a == $past(clk_q))
		else $error("direct route does not carry the clock pin");
	AST_DCC: assert property (@(posedge pclk)
		disable iff (!presetn)
		$changed(div0_route_q) |=>
		duty_correction_on[0] == !$past(div0_route_q[CCD_BIT_DCC_DIS]))
		else $error("duty correction does not follow its disable bit");
	COV_APB_WRITE: cover property (@(posedge pclk) disable iff (!presetn)
		psel && penable && pready_q && pwrite && !pslverr_q);
	COV_SYNC_RELEASE: cover property (@(posedge pclk) disable iff (!presetn)
		!sync_q ##1 sync_q ##[1:40] running_w[0]);
endmodule

//--- hdl/ccd_pkg.sv
// package: register map, field layout, reset values and timing of the oscillator model
package ccd_pkg;
	// bus geometry; register indices are word indices, byte address is 4x
	localparam int unsigned CCD_AW = 12;
	localparam int unsigned CCD_IW = 9;
	localparam logic [8:0] CCD_IDX_DIV0_PHASE = 9'h190;
	localparam logic [8:0] CCD_IDX_DIV0_CTRL = 9'h191;
	localparam logic [8:0] CCD_IDX_DIV0_ROUTE = 9'h192;
	localparam logic [8:0] CCD_IDX_DIV1_PHASE = 9'h193;
	localparam logic [8:0] CCD_IDX_DIV1_CTRL = 9'h194;
	localparam logic [8:0] CCD_IDX_SRC_SEL = 9'h1E1;
	localparam logic [8:0] CCD_IDX_STATUS = 9'h1F0;
	// field positions
	localparam int unsigned CCD_LOW_MSB = 7;
	localparam int unsigned CCD_LOW_LSB = 4;
	localparam int unsigned CCD_HIGH_MSB = 3;
	localparam int unsigned CCD_HIGH_LSB = 0;
	localparam int unsigned CCD_BIT_BYPASS = 7;
	localparam int unsigned CCD_BIT_NOSYNC = 6;
	localparam int unsigned CCD_BIT_FORCE = 5;
	localparam int unsigned CCD_BIT_START = 4;
	localparam int unsigned CCD_OFS_MSB = 3;
	localparam int unsigned CCD_OFS_LSB = 0;
	localparam int unsigned CCD_BIT_DIRECT = 1;
	localparam int unsigned CCD_BIT_DCC_DIS = 0;
	// reset values and writable masks
	localparam logic [7:0] CCD_RST_DIV0_PHASE = 8'h00;
	localparam logic [7:0] CCD_RST_DIV0_CTRL = 8'h80;
	localparam logic [7:0] CCD_RST_DIV0_ROUTE = 8'h00;
	localparam logic [7:0] CCD_RST_DIV1_PHASE = 8'h00;
	localparam logic [7:0] CCD_RST_DIV1_CTRL = 8'h00;
	localparam logic [7:0] CCD_RST_SRC_SEL = 8'h00;
	localparam logic [7:0] CCD_MASK_DIV1_CTRL = 8'hE0;
	localparam logic [7:0] CCD_MASK_ROUTE = 8'h03;
	// source select encodings
	localparam logic [1:0] CCD_SRC_CLK = 2'h0;
	localparam logic [1:0] CCD_SRC_OSC = 2'h2;
	// internal oscillator model: half period from the pclk rate
	localparam int unsigned CCD_PCLK_NS = 25;
	localparam int unsigned CCD_OSC_HALF_NS = 50;
	localparam int unsigned CCD_OSC_HALF_CYC =
		(CCD_OSC_HALF_NS + CCD_PCLK_NS - 1) / CCD_PCLK_NS;
	typedef enum logic [1:0] {CCD_ST_HOLD, CCD_ST_OFFSET, CCD_ST_RUN}
		ccd_state_e;
endpackage

//--- hdl/ccd_div_if.sv
// interface: settings and result of one channel divider
`timescale 1ns/10ps
interface ccd_div_if;
	logic tick;
	logic hold;
	logic start_high;
	logic [3:0] low_len;
	logic [3:0] high_len;
	logic [3:0] phase_off;
	logic level;
	logic running;
	modport ctrl (output tick, hold, start_high, low_len, high_len,
		phase_off, input level, running);
	modport div (input tick, hold, start_high, low_len, high_len,
		phase_off, output level, running);
endinterface

//--- hdl/ccd_divider.sv
// module: one channel divider with phase offset and start level
`timescale 1ns/10ps
module ccd_divider
	import ccd_pkg::*;
(
	input wire logic pclk, // system clock
	input wire logic presetn, // async reset, active low
	ccd_div_if.div dif // settings in, divided level out
);
	ccd_state_e st_q, st_d;
	logic [3:0] cnt_q, cnt_d;
	logic level_q, level_d;

	// next state: hold while synced or bypassed, then offset, then run
	always_comb
	begin
		st_d = st_q;
		cnt_d = cnt_q;
		level_d = level_q;
		case (st_q)
			CCD_ST_HOLD:
			begin
				level_d = dif.start_high;
				cnt_d = 4'h0;
				if (!dif.hold)
				begin
					// zero offset skips the wait entirely
					if (dif.phase_off == 4'h0)
						st_d = CCD_ST_RUN;
					else
						st_d = CCD_ST_OFFSET;
				end
			end
			CCD_ST_OFFSET:
			begin
				if (dif.tick)
				begin
					if (cnt_q + 4'h1 == dif.phase_off)
					begin
						st_d = CCD_ST_RUN;
						cnt_d = 4'h0;
					end
					else
						cnt_d = cnt_q + 4'h1;
				end
			end
			CCD_ST_RUN:
			begin
				if (dif.tick)
				begin
					// phase lasts field plus one input cycles
					if (cnt_q == (level_q ? dif.high_len : dif.low_len))
					begin
						level_d = !level_q;
						cnt_d = 4'h0;
					end
					else
						cnt_d = cnt_q + 4'h1;
				end
			end
			default:
			begin
				st_d = CCD_ST_HOLD;
				cnt_d = 4'h0;
			end
		endcase
		// hold overrides every state, powering the counter down
		if (dif.hold)
		begin
			st_d = CCD_ST_HOLD;
			cnt_d = 4'h0;
		end
	end

	// state registers
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			st_q <= CCD_ST_HOLD;
			cnt_q <= 4'h0;
			level_q <= 1'b0;
		end
		else
		begin
			st_q <= st_d;
			cnt_q <= cnt_d;
			level_q <= level_d;
		end
	end

	assign dif.level = level_q;
	assign dif.running = (st_q == CCD_ST_RUN);

	AST_LOW_END: assert property (@(posedge pclk)
		disable iff (!presetn)
		(st_q == CCD_ST_RUN && dif.tick && !dif.hold && !level_q &&
		cnt_q == dif.low_len) |=> level_q)
		else $error("low phase did not end after low field plus one");
	AST_LOW_EARLY: assert property (@(posedge pclk)
		disable iff (!presetn)
		(st_q == CCD_ST_RUN && !dif.hold && !level_q &&
		cnt_q < dif.low_len) |=> !level_q)
		else $error("low phase ended early");
	AST_HIGH_END: assert property (@(posedge pclk)
		disable iff (!presetn)
		(st_q == CCD_ST_RUN && dif.tick && !dif.hold && level_q &&
		cnt_q == dif.high_len) |=> !level_q)
		else $error("high phase did not end after high field plus one");
	AST_STEADY: assert property (@(posedge pclk)
		disable iff (!presetn)
		(st_q == CCD_ST_RUN && !dif.tick && !dif.hold) |=> $stable(level_q))
		else $error("divided level moved without an input tick");
	AST_HOLD: assert property (@(posedge pclk)
		disable iff (!presetn)
		dif.hold |=> (st_q == CCD_ST_HOLD && cnt_q == 4'h0))
		else $error("divider kept running while held");
	AST_START: assert property (@(posedge pclk)
		disable iff (!presetn)
		(st_q == CCD_ST_HOLD && $past(st_q) == CCD_ST_HOLD) |->
		level_q == $past(dif.start_high))
		else $error("held level differs from start level");
	AST_OFFSET: assert property (@(posedge pclk)
		disable iff (!presetn)
		(st_q == CCD_ST_OFFSET && !dif.hold) |=> $stable(level_q))
		else $error("output moved during phase offset");
	COV_RUN_TOGGLE: cover property (@(posedge pclk) disable iff (!presetn)
		st_q == CCD_ST_RUN && $changed(level_q));
	COV_OFFSET_DONE: cover property (@(posedge pclk) disable iff (!presetn)
		st_q == CCD_ST_OFFSET ##1 st_q == CCD_ST_RUN);
endmodule

//--- sim/ccd_drv_model.sv
// partner model: output driver pair that times each run of the clock
`timescale 1ns/10ps
module ccd_drv_model
(
	input wire logic pclk, // sampling clock
	input wire logic pair_a, // driver input a
	input wire logic pair_b, // driver input b
	output logic rep_v, // pulse: a run has ended
	output logic rep_lvl, // level of the ended run
	output logic [7:0] rep_len, // its length in pclk cycles
	output logic skew // sticky: a and b disagreed
);
	logic last_q = 1'b0;
	logic [7:0] cnt_q = 8'h00;
	initial skew = 1'b0;
	// a driver sees only levels, so runs are timed on the sampling clock
	always @(posedge pclk)
	begin
		rep_v <= (pair_a !== last_q);
		rep_lvl <= last_q;
		rep_len <= cnt_q;
		cnt_q <= (pair_a !== last_q) ? 8'h01 : cnt_q + 8'h01;
		last_q <= pair_a;
		if (pair_a !== pair_b)
			skew <= 1'b1;
	end
endmodule

//--- sim/test_channel_clock_dividers.sv
// testbench: register access, division, sync, force and routing checks
`timescale 1ns/10ps
module test_channel_clock_dividers;
	import ccd_pkg::*;
	localparam int OSC = 3; // oscillator half period of 3 pclk for the run, one more than the default
	logic pclk, presetn, psel, penable, pwrite, clk_in, sync_n;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	logic pready, pslverr;
	wire [1:0] pa, pb, duty, rv, rl, skw;
	wire [1:0][7:0] rn;
	int bad_count, checked;
	logic [9:0] aq[$];
	logic [9:0] rq[$];

	ccd_top #(.OSC_HALF(OSC)) dut (.pclk(pclk), .presetn(presetn),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .clk_in(clk_in), .sync_n(sync_n),
		.first_pair_output_a(pa[0]), .first_pair_output_b(pb[0]),
		.second_pair_output_a(pa[1]), .second_pair_output_b(pb[1]),
		.duty_correction_on(duty));
	ccd_drv_model u_drv0 (.pclk(pclk), .pair_a(pa[0]), .pair_b(pb[0]),
		.rep_v(rv[0]), .rep_lvl(rl[0]), .rep_len(rn[0]), .skew(skw[0]));
	ccd_drv_model u_drv1 (.pclk(pclk), .pair_a(pa[1]), .pair_b(pb[1]),
		.rep_v(rv[1]), .rep_lvl(rl[1]), .rep_len(rn[1]), .skew(skw[1]));

	// pclk 25 ns; clk_in period is 4 pclk and never meets a rising pclk edge
	always #12.5 pclk = ~pclk;
	always #50 clk_in = ~clk_in;

	task summarize;
		$display("checks %0d mismatches %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	task chk(input logic ok, input string m);
		checked++;
		if (ok !== 1'b1)
		begin
			bad_count++;
			$display("ERROR %0t %s", $time, m);
		end
	endtask

	task hang(input string m);
		chk(1'b0, m);
		summarize();
	endtask

	function automatic logic [11:0] ad(input logic [8:0] i);
		return {1'b0, i, 2'b00};
	endfunction

	// one apb transfer; the expected answer is noted before it starts
	task apb(input logic w, input logic [11:0] a, input logic [7:0] d,
		input logic s, input logic [7:0] e, input logic er);
		logic [31:0] r;
		int n;
		r = $urandom;
		n = 0;
		aq.push_back({w, er, e});
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {r[31:8], d};
		pstrb <= {r[3:1], s};
		@(posedge pclk);
		penable <= 1'b1;
		do
		begin
			@(posedge pclk);
			if (++n > 50)
				hang("apb hang");
		end
		while (pready !== 1'b1);
		psel <= 1'b0;
		penable <= 1'b0;
		// idle edge so a following call never drives psel twice in one step
		@(posedge pclk);
	endtask

	task wr(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d, 1'b1, 8'h00, 1'b0);
	endtask

	// skip two periods so old settings are flushed, then expect two more
	task runs(input logic p, input logic [7:0] lo, input logic [7:0] hi);
		int n;
		n = 0;
		repeat (2)
		begin
			do
			begin
				@(posedge pclk);
				if (++n > 900)
					hang("no run end");
			end
			while (!(rv[p] === 1'b1 && rl[p] === 1'b1));
		end
		@(negedge pclk);
		repeat (2)
		begin
			rq.push_back({p, 1'b0, lo});
			rq.push_back({p, 1'b1, hi});
		end
		n = 0;
		while (rq.size() > 0)
		begin
			@(posedge pclk);
			if (++n > 600)
				hang("runs missing");
		end
	endtask

	task hold_lvl(input logic p, input logic l);
		repeat (30) @(posedge pclk);
		repeat (8)
		begin
			@(posedge pclk);
			chk(pa[p] === l, "steady level");
		end
	endtask

	// delay from sync release, aligned to clk_in, to the first edge
	task edge_delay(input logic [7:0] c, output int d);
		d = 0;
		sync_n <= 1'b0;
		wr(ad(CCD_IDX_DIV0_CTRL), c);
		repeat (20) @(posedge pclk);
		chk(pa[0] === 1'b1, "start level");
		@(posedge clk_in);
		@(posedge pclk);
		sync_n <= 1'b1;
		while (pa[0] === 1'b1)
		begin
			@(posedge pclk);
			if (++d > 300)
				hang("no first edge");
		end
	endtask

	// results: apb answers and ended runs against the oldest note
	always @(posedge pclk)
	begin
		if (psel && penable && pready === 1'b1 && aq.size() > 0)
		begin
			chk(pslverr === aq[0][8] && (aq[0][9] ||
				prdata === {24'h00_0000, aq[0][7:0]}), "apb answer");
			void'(aq.pop_front());
		end
		for (int p = 0; p < 2; p++)
			if (rv[p] === 1'b1 && rq.size() > 0 && rq[0][9] == p[0])
			begin
				chk({rl[p], rn[p]} === rq[0][8:0], "run");
				void'(rq.pop_front());
			end
	end

	initial
	begin
		logic [7:0] v;
		int d0;
		int d1;
		pclk = 1'b0;
		clk_in = 1'b0;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		pstrb = 4'h0;
		sync_n = 1'b1;
		presetn = 1'b0;
		bad_count = 0;
		checked = 0;
		v = 8'($urandom(32'hc529));
		repeat (3) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		chk(duty === 2'b11, "dcc reset");
		apb(0, ad(CCD_IDX_DIV0_PHASE), 0, 1, 8'h00, 0);
		apb(0, ad(CCD_IDX_DIV0_CTRL), 0, 1, 8'h80, 0);
		apb(0, ad(CCD_IDX_DIV0_ROUTE), 0, 1, 8'h00, 0);
		apb(0, ad(CCD_IDX_DIV1_PHASE), 0, 1, 8'h00, 0);
		apb(0, ad(CCD_IDX_DIV1_CTRL), 0, 1, 8'h00, 0);
		apb(0, 12'h400, 0, 1, 8'h00, 1);
		apb(0, 12'h641, 0, 1, 8'h00, 1);
		apb(1, ad(CCD_IDX_STATUS), 8'hFF, 1, 8'h00, 1);
		apb(1, ad(CCD_IDX_DIV0_PHASE), 8'hAB, 0, 8'h00, 0);
		apb(0, ad(CCD_IDX_DIV0_PHASE), 0, 1, 8'h00, 0);
		v = 8'($urandom);
		wr(ad(CCD_IDX_DIV0_ROUTE), v);
		apb(0, ad(CCD_IDX_DIV0_ROUTE), 0, 1, v & 8'h03, 0);
		wr(ad(CCD_IDX_DIV1_CTRL), 8'hFF);
		apb(0, ad(CCD_IDX_DIV1_CTRL), 0, 1, 8'hE0, 0);
		$display("test 1 done: register map");
		wr(ad(CCD_IDX_DIV0_ROUTE), 8'h00);
		wr(ad(CCD_IDX_DIV0_CTRL), 8'h80);
		runs(0, 8'd2, 8'd2);
		$display("test 2 done: bypass");
		wr(ad(CCD_IDX_DIV1_CTRL), 8'h00);
		for (int i = 0; i < 4; i++)
		begin
			v = (i == 0) ? 8'h00 : (i == 1) ? 8'hF0 : (i == 2) ? 8'h0F :
				8'($urandom) & 8'h77;
			wr(ad(CCD_IDX_DIV1_PHASE), v);
			runs(1, 8'(4 * v[7:4] + 4), 8'(4 * v[3:0] + 4));
		end
		$display("test 3 done: phase lengths");
		wr(ad(CCD_IDX_DIV1_PHASE), 8'h11);
		sync_n <= 1'b0;
		hold_lvl(1, 1'b0);
		wr(ad(CCD_IDX_DIV1_CTRL), 8'h40);
		runs(1, 8'd8, 8'd8);
		wr(ad(CCD_IDX_DIV1_CTRL), 8'h60);
		hold_lvl(1, 1'b1);
		wr(ad(CCD_IDX_DIV1_CTRL), 8'h20);
		sync_n <= 1'b1;
		runs(1, 8'd8, 8'd8);
		$display("test 4 done: sync and force");
		wr(ad(CCD_IDX_DIV0_PHASE), 8'h11);
		edge_delay(8'h10, d0);
		edge_delay(8'h1F, d1);
		chk(d1 - d0 == 60, "offset delay");
		$display("test 5 done: start level and offset");
		wr(ad(CCD_IDX_DIV0_PHASE), 8'h33);
		wr(ad(CCD_IDX_DIV0_CTRL), 8'h00);
		wr(ad(CCD_IDX_DIV0_ROUTE), 8'h02);
		for (int i = 0; i < 3; i++)
		begin
			wr(ad(CCD_IDX_SRC_SEL), i == 0 ? 8'h00 : i == 1 ? 8'h02 : 8'h01);
			v = i == 0 ? 8'd2 : i == 1 ? 8'(OSC) : 8'd16;
			runs(0, v, v);
		end
		wr(ad(CCD_IDX_DIV0_ROUTE), 8'h01);
		repeat (3) @(posedge pclk);
		chk(duty === 2'b10, "dcc off");
		wr(ad(CCD_IDX_DIV0_ROUTE), 8'h00);
		repeat (3) @(posedge pclk);
		chk(duty === 2'b11, "dcc on");
		chk(skw === 2'b00, "pair skew");
		$display("test 6 done: routing and duty correction");
		summarize();
	end
endmodule
